// [rtl/isx_pkg.sv]
// isx_pkg: shared constants and types
package isx_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned BANK_W = 4;
  localparam int unsigned INSN_W = 16;

  // ****************************************************************
  // opcode fields
  // ****************************************************************
  localparam int unsigned OP6_HI = 15;
  localparam int unsigned OP6_LO = 10;
  localparam int unsigned OP8_LO = 8;
  localparam int unsigned DST_BIT = 9;
  localparam int unsigned ACC_BIT = 8;
  localparam logic [5:0] OPC_INC_NZ = 6'h12;   // 0100 10
  localparam logic [5:0] OPC_INC_Z  = 6'h0F;   // 0011 11
  localparam logic [7:0] OPC_OR_LIT = 8'h09;   // 0000 1001

  // ****************************************************************
  // addressing
  // ****************************************************************
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [7:0] INDEX_LIMIT  = 8'h5F;
  localparam logic [3:0] ACCESS_LOW   = 4'h0;
  localparam logic [3:0] ACCESS_HIGH  = 4'hF;

  // ****************************************************************
  // skip counts and reset values
  // ****************************************************************
  localparam logic [1:0] NOP_NONE = 2'h0;
  localparam logic [1:0] NOP_ONE  = 2'h1;
  localparam logic [1:0] NOP_TWO  = 2'h2;
  localparam logic [7:0] W_RESET  = 8'h00;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    PH_Q1 = 2'h0,
    PH_Q2 = 2'h1,
    PH_Q3 = 2'h3,
    PH_Q4 = 2'h2
  } isx_phase_type;

  typedef enum logic [1:0] {
    OP_NONE   = 2'h0,
    OP_INC_NZ = 2'h1,
    OP_INC_Z  = 2'h2,
    OP_OR_LIT = 2'h3
  } isx_op_type;

  typedef struct packed {
    isx_op_type  kind;
    logic        dst;
    logic        acc;
    logic [7:0]  lit;
  } isx_dec_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              rd;
    logic              wr;
    logic [DATA_W-1:0] wdata;
  } isx_mem_type;

endpackage

// [rtl/isx_addr.sv]
// isx_addr: resolves the 8-bit file field to a data memory address
`timescale 1ns/1ps
`default_nettype none

module isx_addr (
  // operand field
  input  wire logic [7:0]                 fsel,
  input  wire logic                       acc,
  // bank and mode
  input  wire logic [isx_pkg::BANK_W-1:0] bank,
  input  wire logic                       ext_en,
  input  wire logic [isx_pkg::ADDR_W-1:0] index_base,
  // result
  output logic      [isx_pkg::ADDR_W-1:0] addr,
  output logic                            indexed
);

  always_comb begin
    indexed = ext_en && !acc && (fsel <= isx_pkg::INDEX_LIMIT);
    if (indexed) begin
      // offset wraps inside the data space, as the pointer would
      addr = index_base + {4'h0, fsel};
    end else if (acc) begin
      addr = {bank, fsel};
    end else if (fsel < isx_pkg::ACCESS_SPLIT) begin
      addr = {isx_pkg::ACCESS_LOW, fsel};
    end else begin
      addr = {isx_pkg::ACCESS_HIGH, fsel};
    end
  end

endmodule // isx_addr

`default_nettype wire

// [rtl/isx_exec.sv]
// isx_exec: executes increment-and-skip and OR-literal instructions
`timescale 1ns/1ps
`default_nettype none

module isx_exec (
  // clock and reset
  input  wire logic                       MCLK,
  input  wire logic                       RST,
  // fetch pipeline
  input  wire logic [isx_pkg::INSN_W-1:0] INSTR_WORD,
  input  wire logic                       INSTR_VALID,
  input  wire logic                       NEXT_TWO_WORD,
  // mode and bank
  input  wire logic                       EXT_SET_EN,
  input  wire logic [isx_pkg::BANK_W-1:0] BANK_SELECT,
  input  wire logic [isx_pkg::ADDR_W-1:0] INDEX_BASE,
  // data memory
  output logic      [isx_pkg::ADDR_W-1:0] MEM_ADDR,
  output logic                            MEM_RD,
  output logic                            MEM_WR,
  output logic      [isx_pkg::DATA_W-1:0] MEM_WDATA,
  input  wire logic [isx_pkg::DATA_W-1:0] MEM_RDATA,
  // core state
  output logic      [isx_pkg::DATA_W-1:0] WREG,
  output logic                            FLAG_N,
  output logic                            FLAG_Z,
  // sequencing
  output logic      [1:0]                 Q_PHASE,
  output logic                            SKIP_FLUSH,
  output logic                            NOP_CYCLE
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [7:0] inc8(input logic [7:0] v);
    inc8 = 8'(v + isx_pkg::BYTE_ONE);
  endfunction

  function automatic logic skip_on(input isx_pkg::isx_op_type k, input logic [7:0] r);
    skip_on = ((k == isx_pkg::OP_INC_NZ) && (r != isx_pkg::BYTE_ZERO))
           || ((k == isx_pkg::OP_INC_Z) && (r == isx_pkg::BYTE_ZERO));
  endfunction

  isx_pkg::isx_phase_type phase_r;
  isx_pkg::isx_dec_type   dec_r;
  isx_pkg::isx_dec_type   dec_nxt;
  isx_pkg::isx_mem_type   mem_r;
  logic [1:0]             nop_left_r;
  logic [7:0]             w_r;
  logic                   n_r;
  logic                   z_r;
  logic                   flush_r;
  logic                   nop_r;
  logic [isx_pkg::ADDR_W-1:0] res_addr;
  logic                   res_indexed;
  logic [7:0]             instr_f;
  logic [7:0]             inc_val;
  logic                   is_inc;
  logic [7:0]             or_val;

  assign instr_f = INSTR_WORD[7:0];
  assign inc_val = inc8(MEM_RDATA);
  assign is_inc  = (dec_r.kind == isx_pkg::OP_INC_NZ) || (dec_r.kind == isx_pkg::OP_INC_Z);
  assign or_val  = w_r | dec_r.lit;

  // ****************************************************************
  // operand address
  // ****************************************************************
  isx_addr u_addr (
    .fsel       (instr_f),
    .acc        (INSTR_WORD[isx_pkg::ACC_BIT]),
    .bank       (BANK_SELECT),
    .ext_en     (EXT_SET_EN),
    .index_base (INDEX_BASE),
    .addr       (res_addr),
    .indexed    (res_indexed)
  );

  // ****************************************************************
  // decode
  // ****************************************************************
  always_comb begin
    dec_nxt      = '0;
    dec_nxt.kind = isx_pkg::OP_NONE;
    dec_nxt.dst  = INSTR_WORD[isx_pkg::DST_BIT];
    dec_nxt.acc  = INSTR_WORD[isx_pkg::ACC_BIT];
    dec_nxt.lit  = instr_f;
    if (INSTR_VALID && (nop_left_r == isx_pkg::NOP_NONE)) begin
      if (INSTR_WORD[isx_pkg::OP6_HI:isx_pkg::OP6_LO] == isx_pkg::OPC_INC_NZ) begin
        dec_nxt.kind = isx_pkg::OP_INC_NZ;
      end else if (INSTR_WORD[isx_pkg::OP6_HI:isx_pkg::OP6_LO] == isx_pkg::OPC_INC_Z) begin
        dec_nxt.kind = isx_pkg::OP_INC_Z;
      end else if (INSTR_WORD[isx_pkg::OP6_HI:isx_pkg::OP8_LO] == isx_pkg::OPC_OR_LIT) begin
        dec_nxt.kind = isx_pkg::OP_OR_LIT;
      end
    end
  end

  // ****************************************************************
  // four-phase instruction cycle
  // ****************************************************************
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      phase_r <= isx_pkg::PH_Q1;
    end else begin
      unique case (phase_r)
        isx_pkg::PH_Q1: phase_r <= isx_pkg::PH_Q2;
        isx_pkg::PH_Q2: phase_r <= isx_pkg::PH_Q3;
        isx_pkg::PH_Q3: phase_r <= isx_pkg::PH_Q4;
        isx_pkg::PH_Q4: phase_r <= isx_pkg::PH_Q1;
      endcase
    end
  end

  // instruction latched at the close of Q1; held for the whole cycle
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      dec_r <= '0;
      nop_r <= 1'b0;
    end else if (phase_r == isx_pkg::PH_Q1) begin
      dec_r <= dec_nxt;
      nop_r <= (nop_left_r != isx_pkg::NOP_NONE);
    end
  end

  // ****************************************************************
  // data memory: read in Q2, write in Q4
  // ****************************************************************
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      mem_r <= '0;
    end else begin
      unique case (phase_r)
        isx_pkg::PH_Q1: begin
          mem_r.addr <= res_addr;
          mem_r.rd   <= (dec_nxt.kind == isx_pkg::OP_INC_NZ)
                     || (dec_nxt.kind == isx_pkg::OP_INC_Z);
          mem_r.wr   <= 1'b0;
        end
        isx_pkg::PH_Q2: begin
          mem_r.rd <= 1'b0;
        end
        isx_pkg::PH_Q3: begin
          // a clear destination bit leaves the file register alone
          mem_r.wr    <= is_inc && dec_r.dst;
          mem_r.wdata <= inc_val;
        end
        isx_pkg::PH_Q4: begin
          mem_r.wr <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // working register and flags
  // ****************************************************************
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      w_r <= isx_pkg::W_RESET;
      n_r <= 1'b0;
      z_r <= 1'b0;
    end else if (phase_r == isx_pkg::PH_Q3) begin
      if (is_inc && !dec_r.dst) begin
        w_r <= inc_val;
      end else if (dec_r.kind == isx_pkg::OP_OR_LIT) begin
        w_r <= or_val;
        n_r <= or_val[7];
        z_r <= (or_val == isx_pkg::BYTE_ZERO);
      end
    end
  end

  // ****************************************************************
  // skip
  // ****************************************************************
  // the width of the next word is only known to fetch, so it is sampled late
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      nop_left_r <= isx_pkg::NOP_NONE;
      flush_r    <= 1'b0;
    end else begin
      flush_r <= 1'b0;
      if ((phase_r == isx_pkg::PH_Q3) && skip_on(dec_r.kind, inc_val)) begin
        nop_left_r <= NEXT_TWO_WORD ? isx_pkg::NOP_TWO : isx_pkg::NOP_ONE;
        flush_r    <= 1'b1;
      end else if ((phase_r == isx_pkg::PH_Q1) && (nop_left_r != isx_pkg::NOP_NONE)) begin
        nop_left_r <= 2'(nop_left_r - isx_pkg::NOP_ONE);
      end
    end
  end

  assign MEM_ADDR   = mem_r.addr;
  assign MEM_RD     = mem_r.rd;
  assign MEM_WR     = mem_r.wr;
  assign MEM_WDATA  = mem_r.wdata;
  assign WREG       = w_r;
  assign FLAG_N     = n_r;
  assign FLAG_Z     = z_r;
  assign Q_PHASE    = phase_r;
  assign SKIP_FLUSH = flush_r;
  assign NOP_CYCLE  = nop_r;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  logic q3_inc;
  assign q3_inc = (phase_r == isx_pkg::PH_Q3) && is_inc;

  property p_nz_skip;
    (phase_r == isx_pkg::PH_Q3) && (dec_r.kind == isx_pkg::OP_INC_NZ)
      && (MEM_RDATA != 8'hFF) |=> SKIP_FLUSH && (nop_left_r != 2'h0);
  endproperty
  a_nz_skip: assert property (p_nz_skip) else $error("no skip on nonzero result");

  property p_z_skip;
    (phase_r == isx_pkg::PH_Q3) && (dec_r.kind == isx_pkg::OP_INC_Z)
      |=> SKIP_FLUSH == ($past(MEM_RDATA) == 8'hFF);
  endproperty
  a_z_skip: assert property (p_z_skip) else $error("zero skip decision wrong");

  property p_two_word;
    (phase_r == isx_pkg::PH_Q3) && is_inc && skip_on(dec_r.kind, inc_val) && NEXT_TWO_WORD
      |=> (nop_left_r == 2'h2) ##4 NOP_CYCLE ##4 NOP_CYCLE;
  endproperty
  a_two_word: assert property (p_two_word) else $error("two-word skip not two cycles");

  property p_wr_back;
    q3_inc && dec_r.dst |=> MEM_WR && (MEM_WDATA == 8'($past(MEM_RDATA) + 8'h01))
      && $stable(WREG);
  endproperty
  a_wr_back: assert property (p_wr_back) else $error("file write-back wrong");

  property p_to_w;
    q3_inc && !dec_r.dst |=> !MEM_WR && (WREG == 8'($past(MEM_RDATA) + 8'h01));
  endproperty
  a_to_w: assert property (p_to_w) else $error("working register result wrong");

  property p_no_flags;
    q3_inc |=> $stable(FLAG_N) && $stable(FLAG_Z);
  endproperty
  a_no_flags: assert property (p_no_flags) else $error("increment touched flags");

  property p_or;
    (phase_r == isx_pkg::PH_Q3) && (dec_r.kind == isx_pkg::OP_OR_LIT)
      |=> (WREG == ($past(w_r) | $past(dec_r.lit))) && (FLAG_Z == (WREG == 8'h00))
      && (FLAG_N == WREG[7]) && !MEM_WR;
  endproperty
  a_or: assert property (p_or) else $error("or literal result wrong");

  property p_bank;
    (phase_r == isx_pkg::PH_Q1) && INSTR_WORD[isx_pkg::ACC_BIT]
      |=> MEM_ADDR == {$past(BANK_SELECT), $past(instr_f)};
  endproperty
  a_bank: assert property (p_bank) else $error("bank select not used");

  property p_indexed;
    (phase_r == isx_pkg::PH_Q1) && EXT_SET_EN && !INSTR_WORD[isx_pkg::ACC_BIT]
      && (instr_f <= 8'h5F) |=> MEM_ADDR == 12'($past(INDEX_BASE) + {4'h0, $past(instr_f)});
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed offset address wrong");

  property p_acc_bank;
    (phase_r == isx_pkg::PH_Q1) && !INSTR_WORD[isx_pkg::ACC_BIT]
      && !(EXT_SET_EN && (instr_f <= 8'h5F))
      |=> !$past(res_indexed)
      && (MEM_ADDR == {(($past(instr_f) < 8'h60) ? 4'h0 : 4'hF), $past(instr_f)});
  endproperty
  a_acc_bank: assert property (p_acc_bank) else $error("access bank not used");

  property p_discard;
    (phase_r == isx_pkg::PH_Q1) && (nop_left_r != 2'h0)
      |=> (dec_r.kind == isx_pkg::OP_NONE) && NOP_CYCLE && !MEM_RD;
  endproperty
  a_discard: assert property (p_discard) else $error("skipped instruction executed");

endmodule // isx_exec

`default_nettype wire

// [verif/isx_mem_model.sv]
// isx_mem_model: behavioural data memory on the far side of the execution block
`timescale 1ns/1ps
`default_nettype none

module isx_mem_model (
  // clock
  input  wire logic                       MCLK,
  // memory port
  input  wire logic [isx_pkg::ADDR_W-1:0] MEM_ADDR,
  input  wire logic                       MEM_RD,
  input  wire logic                       MEM_WR,
  input  wire logic [isx_pkg::DATA_W-1:0] MEM_WDATA,
  output logic      [isx_pkg::DATA_W-1:0] MEM_RDATA
);
  logic [7:0] mem [4096];

  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = i[7:0] ^ 8'h5A;
    end
    MEM_RDATA = 8'hA5;
  end

  // ****************************************************************
  // read and write
  // ****************************************************************
  // outside a read the bus flips every cycle so a badly timed sample never matches by luck
  always @(posedge MCLK) begin
    if (MEM_WR) begin
      mem[MEM_ADDR] <= MEM_WDATA;
    end
    MEM_RDATA <= MEM_RD ? mem[MEM_ADDR] : ~MEM_RDATA;
  end
endmodule // isx_mem_model

`default_nettype wire

// [verif/increment_skip_and_or_literal_exec_tb.sv]
// increment_skip_and_or_literal_exec_tb: self-checking bench for the execution block
`timescale 1ns/1ps
`default_nettype none

module increment_skip_and_or_literal_exec_tb;
  logic        mclk, rst, vld, two, ext, mrd, mwr, flush, nopc, fn, fz, n_exp, z_exp;
  logic [15:0] wd;
  logic [3:0]  bnk;
  logic [11:0] ib, maddr;
  logic [7:0]  wdat, rdat, wreg, w_exp;
  logic [1:0]  qph;
  logic [7:0]  fv [4] = '{8'h00, 8'h5F, 8'h60, 8'hFF};
  int          pend, errors, checks;

  isx_exec dut_u (
    .MCLK(mclk), .RST(rst), .INSTR_WORD(wd), .INSTR_VALID(vld), .NEXT_TWO_WORD(two),
    .EXT_SET_EN(ext), .BANK_SELECT(bnk), .INDEX_BASE(ib), .MEM_ADDR(maddr), .MEM_RD(mrd),
    .MEM_WR(mwr), .MEM_WDATA(wdat), .MEM_RDATA(rdat), .WREG(wreg), .FLAG_N(fn), .FLAG_Z(fz),
    .Q_PHASE(qph), .SKIP_FLUSH(flush), .NOP_CYCLE(nopc));
  isx_mem_model mem_u (
    .MCLK(mclk), .MEM_ADDR(maddr), .MEM_RD(mrd), .MEM_WR(mwr), .MEM_WDATA(wdat),
    .MEM_RDATA(rdat));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic done(input string s);
    $display("test %s done: checks=%0d errors=%0d", s, checks, errors);
  endtask

  task automatic step();
    @(posedge mclk);
    #2;
  endtask

  function automatic logic [11:0] exp_addr(input logic [7:0] f, input logic a);
    if (a) return {bnk, f};
    if (ext && f <= isx_pkg::INDEX_LIMIT) return ib + {4'h0, f};
    return {(f < isx_pkg::ACCESS_SPLIT) ? isx_pkg::ACCESS_LOW : isx_pkg::ACCESS_HIGH, f};
  endfunction

  // one instruction cycle; pre[8] set preloads the operand byte
  task automatic slot(input logic [15:0] w, input logic v, input logic t2, input logic [8:0] pre);
    logic [11:0] a;
    logic [7:0]  res;
    logic        inc, isnz, isor, no_operation, skp, d;
    int          i;
    for (i = 0; i < 8 && qph !== 2'h0; i++) step();
    if (i == 8) begin
      errors++;
      close_out();
    end
    isnz = w[15:10] == isx_pkg::OPC_INC_NZ;
    isor = w[15:8] == isx_pkg::OPC_OR_LIT;
    no_operation = pend > 0;
    inc = v && !no_operation && (isnz || w[15:10] == isx_pkg::OPC_INC_Z);
    d = w[9];
    a = exp_addr(w[7:0], w[8]);
    if (pre[8]) mem_u.mem[a] = pre[7:0];
    res = mem_u.mem[a] + 8'h01;
    wd = w;
    vld = v;
    two = t2;
    step();
    chk(qph, isx_pkg::PH_Q2);
    chk(mrd, inc);
    chk(nopc, no_operation);
    if (inc) chk(maddr, a);
    step();
    step();
    skp = inc && (isnz ? res != 8'h00 : res == 8'h00);
    chk(flush, skp);
    chk(mwr, inc && d);
    if (inc && d) chk(wdat, res);
    if (inc && !d) w_exp = res;
    if (isor && v && !no_operation) begin
      w_exp = w_exp | w[7:0];
      n_exp = w_exp[7];
      z_exp = w_exp == 8'h00;
    end
    chk(wreg, w_exp);
    chk({fn, fz}, {n_exp, z_exp});
    if (no_operation) pend--;
    if (skp) pend = t2 ? 2 : 1;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    int          n;
    logic [31:0] r;
    logic [15:0] w;
    rst = 1'b1;
    wd = 16'h0000;
    vld = 1'b0;
    two = 1'b0;
    ext = 1'b0;
    bnk = 4'h3;
    ib = 12'h400;
    errors = 0;
    checks = 0;
    pend = 0;
    w_exp = 8'h00;
    n_exp = 1'b0;
    z_exp = 1'b0;
    n = $urandom(32'h336B44AC);
    repeat (5) @(posedge mclk);
    #2;
    rst = 1'b0;
    chk({wreg, fn, fz}, 10'h000);
    slot(16'h0900, 1'b1, 1'b0, 9'h000);
    slot(16'h099A, 1'b1, 1'b0, 9'h000);
    slot(16'h0935, 1'b1, 1'b0, 9'h000);
    done("or literal");
    slot({isx_pkg::OPC_INC_NZ, 2'b11, 8'h40}, 1'b1, 1'b0, 9'h105);
    slot(16'h0940, 1'b1, 1'b0, 9'h000);
    slot({isx_pkg::OPC_INC_NZ, 2'b01, 8'h40}, 1'b1, 1'b0, 9'h1FF);
    slot({isx_pkg::OPC_INC_Z, 2'b01, 8'h41}, 1'b1, 1'b1, 9'h1FF);
    slot(16'h0901, 1'b1, 1'b0, 9'h000);
    slot(16'h0902, 1'b1, 1'b0, 9'h000);
    slot(16'h0904, 1'b1, 1'b0, 9'h000);
    done("skips");
    for (int k = 0; k < 8; k++) begin
      ext = k[0];
      slot({isx_pkg::OPC_INC_Z, 2'b10, fv[k >> 1]}, 1'b1, 1'b0, 9'h110);
    end
    slot(16'hFFFF, 1'b1, 1'b0, 9'h000);
    slot({isx_pkg::OPC_INC_NZ, 2'b11, 8'h20}, 1'b0, 1'b0, 9'h100);
    done("addressing and refusals");
    repeat (300) begin
      r = $urandom;
      bnk = r[3:0];
      ext = r[4];
      ib = r[16:5];
      r = $urandom;
      case (r[17:16])
        2'h0: w = {isx_pkg::OPC_INC_NZ, r[9:0]};
        2'h1: w = {isx_pkg::OPC_INC_Z, r[9:0]};
        2'h2: w = {isx_pkg::OPC_OR_LIT, r[7:0]};
        default: w = r[15:0];
      endcase
      // operand all ones a quarter of the time to reach the wrap
      slot(w, r[20:18] != 3'h0, r[21], {r[23:22] == 2'h0, 8'hFF});
    end
    done("random");
    rst = 1'b1;
    step();
    rst = 1'b0;
    w_exp = 8'h00;
    n_exp = 1'b0;
    z_exp = 1'b0;
    pend = 0;
    chk({wreg, fn, fz, flush, nopc}, 12'h000);
    slot(16'h0900, 1'b1, 1'b0, 9'h000);
    done("second reset");
    close_out();
  end
endmodule // increment_skip_and_or_literal_exec_tb

`default_nettype wire
